// file: design/lso_pkg.sv
package lso_pkg;
  // clock control register layout, printed offset is a word index
  typedef struct packed {
    logic lsSel;        // low-speed source: 0 crystal, 1 rc
    logic osc;          // requested system clock: 0 crystal, 1 rc
    logic [2:0] tickDiv;
    logic [2:0] sysDiv;
  } lso_clock_control_reg_t;

  // oscillator power-up enables
  typedef struct packed {
    logic lsRc;
    logic lsXtal;
    logic hsRc;
    logic hsXtal;
  } lso_osc_en_t;

  // low-speed rc calibration sequencer
  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_INIT = 2'b01,
    CAL_RUN = 2'b10,
    CAL_ABORT = 2'b11
  } lso_cal_state_t;

  // register word indices, byte address is four times the index
  localparam logic [9:0] CLOCK_CONTROL_REG_IDX = 10'h0c6;
  localparam logic [9:0] SLEEP_IDX = 10'h0c7;
  localparam logic [9:0] STATUS_IDX = 10'h0c8;
  localparam lso_clock_control_reg_t CLOCK_CONTROL_REG_RST = 8'hc9;
  localparam lso_osc_en_t OSC_EN_RST = 4'ha;

  // timing, 200 MHz system clock
  localparam int CLK_MHZ = 200;
  localparam int LSRC_CAL_US = 2000;
  localparam int ABORT_US = 130;
  localparam int LSRC_CAL_CYCLES = LSRC_CAL_US * CLK_MHZ;
  localparam int ABORT_CYCLES = ABORT_US * CLK_MHZ;
  localparam logic [11:0] HSRC_CAL_CYCLES = 12'h3e8;
  localparam int CNT_W = 20;
  localparam int TICK_W = 7;
endpackage

// file: design/lso_clock_ctrl.sv
// The APB register port was decided locally.
`timescale 1ns/1ps
// How it works
// - rc calibration runs only with rc on and fast crystal enabled and stable
// - exactly one of the two low-speed oscillators is enabled at any time
// - reset enables the low-power rc and selects it as low-speed source
// - switching to fast crystal with rc selected starts an rc calibration
// - calibration repeats while on fast crystal in active mode only, never in any sleep mode
// - a finished calibration leaves the rc at its nominal 32 kHz target
// - one calibration pass takes about 2 ms
// - later calibrations are aborted by a switch to fast rc or deep sleep
// - during the first calibration such requests wait until it completes
// - after the first calibration the request acts about 130 us later
// - bit 7 picks 32.768 kHz crystal when 0, low-power rc when 1
// - clock select acts only once source is stable, and a switch to fast rc only once fast rc calibrated
// - timer tick field never exceeds the system clock speed field
// - tick code n divides by 2^n, code 0 only on fast crystal
// - system clock never switches before the new source reports stable
// - switching to fast crystal starts a one-time fast rc calibration
module lso_clock_ctrl #(
  parameter int CAL_CYC = lso_pkg::LSRC_CAL_CYCLES,
  parameter int ABORT_CYC = lso_pkg::ABORT_CYCLES
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error, unmapped address
  input wire logic xtalStable, // fast crystal stable, async pin
  input wire logic rcStable, // fast rc stable, async pin
  output lso_pkg::lso_osc_en_t oscEn, // oscillator enables
  output logic sysClkSel, // active system clock: 0 crystal, 1 rc
  output logic lsRcCalRun, // low-power rc calibration running
  output logic [1:0] sleepMode, // entered sleep mode, 0 active
  output logic timerTick // timer prescaler enable pulse
);
  import lso_pkg::*;

  lso_clock_control_reg_t clkCtrl;
  lso_cal_state_t calState, next_calState;
  logic [CNT_W-1:0] calCnt, next_calCnt;
  logic [1:0] xtalSync, rcSync;
  logic xtalStableS, rcStableS;
  logic [1:0] sleepReq;
  logic [11:0] hsCnt;
  logic hsRcCalBusy, calInitial;
  logic calAllowed, pendingSleep, pendingRc, pendingReq;
  logic goXtal, goRc, goSleep;
  logic apbWr, apbSetup;
  logic [9:0] wordIdx;
  lso_clock_control_reg_t wrVal;
  logic [TICK_W-1:0] tickCnt;

  // effective tick divider exponent, code 0 not usable on fast rc
  function automatic logic [2:0] effTick(input logic [2:0] code, input logic onRc);
    effTick = (onRc && code == 3'h0) ? 3'h1 : code;
  endfunction

  // bit mask selecting the tick counter bits for a divide by 2^n
  function automatic logic [TICK_W-1:0] tickMask(input logic [2:0] n);
    tickMask = TICK_W'((8'h01 << n) - 8'h01);
  endfunction

  // two-flop synchronisers for the stability pins
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      xtalSync <= 2'h0;
      rcSync <= 2'h0;
    end else begin
      xtalSync <= {xtalSync[0], xtalStable};
      rcSync <= {rcSync[0], rcStable};
    end
  end
  assign xtalStableS = xtalSync[1];
  assign rcStableS = rcSync[1];

  // apb decode
  assign wordIdx = paddr[11:2];
  assign apbSetup = psel && !penable;
  assign apbWr = psel && penable && pready && pwrite;
  always_comb begin
    wrVal = lso_clock_control_reg_t'(pwdata[7:0]);
    if (wrVal.tickDiv > wrVal.sysDiv) begin
      wrVal.tickDiv = wrVal.sysDiv;
    end
  end

  // apb answer, ready and read data prepared in the setup cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= apbSetup;
      if (apbSetup) begin
        pslverr <= !(wordIdx inside {CLOCK_CONTROL_REG_IDX, SLEEP_IDX, STATUS_IDX});
        unique case (wordIdx)
          CLOCK_CONTROL_REG_IDX: prdata <= {24'h0, clkCtrl};
          SLEEP_IDX: prdata <= {30'h0, sleepReq};
          STATUS_IDX: prdata <= {20'h0, sleepMode, calInitial, lsRcCalRun, hsRcCalBusy,
                                 sysClkSel, oscEn, xtalStableS, rcStableS};
          default: prdata <= 32'h0;
        endcase
      end
    end
  end

  // clock control and sleep request registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      clkCtrl <= CLOCK_CONTROL_REG_RST;
      sleepReq <= 2'h0;
    end else if (apbWr && wordIdx == CLOCK_CONTROL_REG_IDX) begin
      clkCtrl <= wrVal;
    end else if (apbWr && wordIdx == SLEEP_IDX) begin
      sleepReq <= pwdata[1:0];
    end
  end

  // oscillator enables follow the selects; selecting a source powers it
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oscEn <= OSC_EN_RST;
    end else begin
      oscEn.lsRc <= clkCtrl.lsSel;
      oscEn.lsXtal <= !clkCtrl.lsSel;
      oscEn.hsXtal <= !clkCtrl.osc || !sysClkSel;
      oscEn.hsRc <= clkCtrl.osc || sysClkSel || hsRcCalBusy;
    end
  end

  // pending software requests that end or pause calibration
  assign pendingRc = clkCtrl.osc && !sysClkSel;
  assign pendingSleep = sleepReq != 2'h0 && sleepMode == 2'h0;
  assign pendingReq = pendingRc || pendingSleep;
  assign calAllowed = oscEn.lsRc && oscEn.hsXtal && xtalStableS && sleepMode == 2'h0;

  // switch and sleep entry happen only once calibration has let go
  assign goXtal = sysClkSel && !clkCtrl.osc && xtalStableS && oscEn.hsXtal
                  && sleepMode == 2'h0;
  assign goRc = pendingRc && calState == CAL_IDLE && !hsRcCalBusy && rcStableS;
  assign goSleep = pendingSleep && calState == CAL_IDLE && !hsRcCalBusy;

  // active system clock source
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sysClkSel <= 1'b1;
    end else if (goXtal) begin
      sysClkSel <= 1'b0;
    end else if (goRc) begin
      sysClkSel <= 1'b1;
    end
  end

  // sleep mode entry, software wakes by writing mode 0
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sleepMode <= 2'h0;
    end else if (goSleep) begin
      sleepMode <= sleepReq;
    end else if (sleepReq == 2'h0) begin
      sleepMode <= 2'h0;
    end
  end

  // one-time fast rc calibration on each switch to the fast crystal
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hsCnt <= 12'h0;
    end else if (goXtal) begin
      hsCnt <= HSRC_CAL_CYCLES;
    end else if (hsCnt != 12'h0) begin
      hsCnt <= hsCnt - 12'h1;
    end
  end
  assign hsRcCalBusy = hsCnt != 12'h0;

  // low-power rc calibration sequencer
  always_comb begin
    next_calState = calState;
    next_calCnt = calCnt;
    unique case (calState)
      CAL_IDLE: begin
        if (!sysClkSel && clkCtrl.lsSel && calAllowed && !pendingReq) begin
          next_calState = CAL_INIT;
          next_calCnt = CNT_W'(CAL_CYC - 1);
        end
      end
      CAL_INIT: begin
        if (!calAllowed || !clkCtrl.lsSel) begin
          next_calState = CAL_IDLE;
        end else if (calCnt == '0) begin
          next_calState = pendingReq ? CAL_IDLE : CAL_RUN;
          next_calCnt = CNT_W'(CAL_CYC - 1);
        end else begin
          next_calCnt = calCnt - 1'b1;
        end
      end
      CAL_RUN: begin
        if (!calAllowed || !clkCtrl.lsSel) begin
          next_calState = CAL_IDLE;
        end else if (pendingReq) begin
          next_calState = CAL_ABORT;
          next_calCnt = CNT_W'(ABORT_CYC - 1);
        end else if (calCnt == '0) begin
          next_calCnt = CNT_W'(CAL_CYC - 1);
        end else begin
          next_calCnt = calCnt - 1'b1;
        end
      end
      CAL_ABORT: begin
        if (calCnt == '0) begin
          next_calState = CAL_IDLE;
        end else begin
          next_calCnt = calCnt - 1'b1;
        end
      end
    endcase
  end

  // sequencer registers and busy flags
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      calState <= CAL_IDLE;
      calCnt <= '0;
      lsRcCalRun <= 1'b0;
      calInitial <= 1'b0;
    end else begin
      calState <= next_calState;
      calCnt <= next_calCnt;
      lsRcCalRun <= next_calState != CAL_IDLE;
      calInitial <= next_calState == CAL_INIT;
    end
  end

  // timer tick prescaler, one-cycle enable every 2^n cycles
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tickCnt <= '0;
      timerTick <= 1'b0;
    end else begin
      tickCnt <= tickCnt + 1'b1;
      timerTick <= (tickCnt & tickMask(effTick(clkCtrl.tickDiv, sysClkSel))) == '0;
    end
  end

  calib_gate_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_INIT || calState == CAL_RUN) |-> $past(calAllowed))
    else $error("calibration ran without stable crystal and running rc");

  one_lsosc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    oscEn.lsRc != oscEn.lsXtal)
    else $error("low-speed oscillators not mutually exclusive");

  reset_rc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $past(!reset_n) |-> oscEn.lsRc && clkCtrl.lsSel && !oscEn.lsXtal)
    else $error("rc not selected after reset");

  start_cal_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_IDLE && !sysClkSel && clkCtrl.lsSel && calAllowed && !pendingReq)
    |=> calState == CAL_INIT && calCnt == CNT_W'(CAL_CYC - 1))
    else $error("calibration did not start on crystal");

  init_hold_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_INIT && calAllowed && clkCtrl.lsSel && calCnt != '0)
    |=> calState == CAL_INIT && !goRc && !goSleep)
    else $error("initial calibration interrupted");

  abort_delay_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_RUN && calAllowed && clkCtrl.lsSel && pendingReq)
    |=> calState == CAL_ABORT && calCnt == CNT_W'(ABORT_CYC - 1))
    else $error("abort delay not loaded");

  tick_clamp_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    clkCtrl.tickDiv <= clkCtrl.sysDiv)
    else $error("tick field above clock speed field");

  tick_rc_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (timerTick && sysClkSel && $past(sysClkSel)) |=> !timerTick)
    else $error("undivided tick on fast rc");

  switch_stable_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ($rose(sysClkSel) |-> $past(rcStableS)) and ($fell(sysClkSel) |-> $past(xtalStableS)))
    else $error("clock switched to unstable source");

  hsrc_cal_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $fell(sysClkSel) |-> hsRcCalBusy ##1 (!sysClkSel)[*2])
    else $error("fast rc calibration not started");

  rc_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(sysClkSel) |-> $past(calState == CAL_IDLE && !hsRcCalBusy))
    else $error("switch to rc during calibration");

  // deep sleep is entered only once the sequencer has let go
  sleep_wait_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    $rose(sleepMode != 2'h0) |-> $past(calState == CAL_IDLE && !hsRcCalBusy))
    else $error("sleep entered during calibration");

  // abort wait ends in idle when its counter runs out
  abort_end_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_ABORT && calCnt == '0) |=> calState == CAL_IDLE)
    else $error("abort wait did not end");

  // a deferred request releases the sequencer after the first pass
  init_done_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_INIT && calAllowed && clkCtrl.lsSel && calCnt == '0 && pendingReq)
    |=> calState == CAL_IDLE)
    else $error("deferred request not released after first pass");

  // with nothing pending a finished pass reloads for the next one
  run_repeat_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (calState == CAL_RUN && calAllowed && clkCtrl.lsSel && !pendingReq && calCnt == '0)
    |=> calState == CAL_RUN && calCnt == CNT_W'(CAL_CYC - 1))
    else $error("calibration did not repeat");

  // the crystal stays powered while it clocks the system
  xtal_power_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !sysClkSel |-> oscEn.hsXtal)
    else $error("fast crystal off while selected");

  // no calibration pass runs in deep sleep
  sleep_cal_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (sleepMode != 2'h0) |-> !(calState inside {CAL_INIT, CAL_RUN}))
    else $error("calibration running in deep sleep");

  // low-speed rc enable follows the select bit one cycle later
  ls_follow_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    oscEn.lsRc == $past(clkCtrl.lsSel))
    else $error("low-speed enable does not follow select");

  // fast rc calibration keeps the system on the crystal
  hs_busy_a: assert property (@(posedge sys_clk) disable iff (!reset_n)
    hsRcCalBusy |-> !sysClkSel)
    else $error("on fast rc during its calibration");
endmodule

// file: dv/lso_clock_ctrl_tb.sv
`timescale 1ns/1ps
module tb;
  import lso_pkg::*;
  localparam int CAL = 2000;
  localparam int ABT = 300;
  logic sys_clk, reset_n, psel, penable, pwrite, xtalStable, rcStable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, sysClkSel, lsRcCalRun, timerTick, er;
  logic [1:0] sleepMode;
  lso_osc_en_t oscEn;
  int err_count, samples_checked, cyc, n, seed;
  logic [7:0] w;
  // byte addresses from word indices
  localparam logic [11:0] A_CLK = {CLOCK_CONTROL_REG_IDX, 2'b00};
  localparam logic [11:0] A_SLP = {SLEEP_IDX, 2'b00};
  localparam logic [11:0] A_STS = {STATUS_IDX, 2'b00};

  lso_clock_ctrl #(.CAL_CYC(CAL), .ABORT_CYC(ABT)) dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .xtalStable(xtalStable), .rcStable(rcStable), .oscEn(oscEn), .sysClkSel(sysClkSel),
    .lsRcCalRun(lsRcCalRun), .sleepMode(sleepMode), .timerTick(timerTick));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // clamp of tick field against the written speed field
  function automatic logic [31:0] exp_clk(input logic [7:0] d);
    logic [7:0] e;
    e = d;
    if (d[5:3] > d[2:0]) e[5:3] = d[2:0];
    return {24'h0, e};
  endfunction

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // cycles until clock select (which 0) or sleep mode (which 1) reaches v
  task automatic wait_for(input int which, input logic [1:0] v, input int lim);
    n = 0;
    while (((which == 0) ? {1'b0, sysClkSel} : sleepMode) !== v && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
  endtask

  // distance between two tick pulses
  task automatic tick_per(input logic [31:0] e);
    int k;
    k = 0;
    while (timerTick !== 1'b1 && k < 300) begin @(posedge sys_clk); k++; end
    k = 0;
    do begin @(posedge sys_clk); k++; end while (timerTick !== 1'b1 && k < 300);
    chk("tick period", e, k);
  endtask

  // hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      err_count++;
      finish_test();
    end
  end

  initial begin
    seed = 32'hc007;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    xtalStable = 1'b0; rcStable = 1'b1; reset_n = 1'b0; cyc = 0;
    err_count = 0; samples_checked = 0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    // reset state and register layout
    chk("oscEn rst", 4'ha, oscEn);
    chk("sysClkSel rst", 1, sysClkSel);
    apb(0, A_CLK, 0); chk("clock_control_reg rst", 32'hc9, rd);
    apb(0, 12'h7fc, 0); chk("unmapped err", 1, er);
    apb(1, A_STS, 32'hffff); chk("status wr err", 0, er);
    // random writes on fast rc, tick clamp
    repeat (8) begin
      w = 8'hc0 | 8'($random(seed) & 32'h3f);
      apb(1, A_CLK, w);
      apb(0, A_CLK, 0); chk("clock_control_reg clamp", exp_clk(w), rd);
    end
    for (int c = 0; c < 4; c++) begin
      apb(1, A_CLK, 8'hc7 | (c << 3));
      tick_per((c == 0) ? 2 : (1 << c));
    end
    // switch to crystal: held off until crystal stable
    apb(1, A_CLK, 8'h89);
    repeat (20) @(posedge sys_clk);
    chk("no switch unstable", 1, sysClkSel);
    xtalStable <= 1'b1;
    wait_for(0, 0, 60);
    chk("switch xtal", 0, sysClkSel);
    chk("hsXtal on", 1, oscEn.hsXtal);
    repeat (3) @(posedge sys_clk);
    chk("cal starts", 1, lsRcCalRun);
    apb(1, A_CLK, 8'h80);
    tick_per(1);
    // request during the initial calibration waits for it
    apb(1, A_CLK, 8'hc9);
    wait_for(0, 1, CAL + 200);
    chk("initial defer", 1, (n > CAL - 200) && (n <= CAL + 60));
    // later passes are aborted after the abort delay
    apb(1, A_CLK, 8'h89);
    wait_for(0, 0, 60);
    repeat (CAL + 100) @(posedge sys_clk);
    chk("continuous cal", 1, lsRcCalRun);
    apb(1, A_CLK, 8'hc9);
    wait_for(0, 1, ABT + 100);
    chk("abort delay", 1, (n >= ABT - 5) && (n <= ABT + 20));
    chk("cal stopped", 0, lsRcCalRun);
    // deep sleep request aborts a later pass
    apb(1, A_CLK, 8'h89);
    wait_for(0, 0, 60);
    repeat (CAL + 100) @(posedge sys_clk);
    apb(1, A_SLP, 2);
    wait_for(1, 2, ABT + 100);
    chk("sleep delay", 1, (n >= ABT - 5) && (n <= ABT + 20));
    apb(1, A_SLP, 0);
    wait_for(1, 0, 20);
    chk("woken", 0, sleepMode);
    apb(1, A_CLK, 8'hc9);
    wait_for(0, 1, CAL + 200);
    chk("back on rc", 1, sysClkSel);
    // low-speed crystal: one source only, no calibration
    apb(1, A_CLK, 8'h49);
    repeat (4) @(posedge sys_clk);
    chk("ls one source", 2'b01, {oscEn.lsRc, oscEn.lsXtal});
    apb(1, A_CLK, 8'h09);
    wait_for(0, 0, 60);
    repeat (5) @(posedge sys_clk);
    chk("no cal on ls xtal", 0, lsRcCalRun);
    finish_test();
  end
endmodule
